// [tb_top.sv]
`include "tpc_map.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tpc_pkg::*;
  logic clk, rst, reg_wr, reg_rd, mem_rd_req, mem_rd_valid, mem_rd_err, exec_start, exec_done;
  logic attention_event, fatal_error, msg_wr_req, msg_ack, msg_wr_done, irq;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, mem_rd_addr, mem_rd_data, err_addr, s;
  logic [4:0]  lat;
  tpc_exec_type exec_cmd, ex_r;
  tpc_msg_type  msg_kind, mk_r;
  logic         ma_r;
  int n_errors, compares, n_rd, n_ex, n_msg, m0, e0;
  logic [4:0] codes [8] = '{5'h01, 5'h04, 5'h05, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0F};

  tpc_core u_tpc_core (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .mem_rd_err(mem_rd_err), .exec_start(exec_start), .exec_cmd(exec_cmd),
    .exec_done(exec_done), .attention_event(attention_event), .fatal_error(fatal_error),
    .msg_wr_req(msg_wr_req), .msg_kind(msg_kind), .msg_ack(msg_ack),
    .msg_wr_done(msg_wr_done), .irq(irq));
  tpc_host_model u_tpc_host_model (.clk(clk), .rst(rst), .lat(lat), .err_addr(err_addr),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data), .mem_rd_err(mem_rd_err), .exec_start(exec_start),
    .exec_done(exec_done), .msg_wr_req(msg_wr_req), .msg_wr_done(msg_wr_done));

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // traffic monitor: registered pulses are sampled before their edge updates land
  always @(posedge clk) begin
    if (mem_rd_req === 1'h1) n_rd++;
    if (exec_start === 1'h1) begin n_ex++; ex_r = exec_cmd; end
    if (msg_wr_req === 1'h1) begin n_msg++; mk_r = msg_kind; ma_r = msg_ack; end
  end

  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd

  // waits for a new message if one is due, then for the ready flag
  task automatic settle(input int want_msg);
    for (int i = 0; i < 200 && want_msg != 0 && n_msg == m0; i++) @(posedge clk);
    s = 16'h0000;
    for (int i = 0; i < 200 && s[7] !== 1'h1; i++) rd(`TPC_OFS_STATUS_WORD, s);
  endtask : settle

  task automatic run(input logic [15:0] p, input int nrd, input int nmsg, input tpc_msg_type k,
                     input logic a, input logic [15:0] st);
    int r0;
    r0 = n_rd;
    m0 = n_msg;
    wr(`TPC_OFS_CMD_PTR, p);
    settle(nmsg);
    `CHK(n_rd - r0, nrd)
    `CHK(n_msg - m0, nmsg)
    if (nmsg != 0) begin
      `CHK(mk_r, k)
      `CHK(ma_r, a)
    end
    if (st != 16'hFFFF) `CHK(s, st)
  endtask : run

  task automatic raise_event;
    m0 = n_msg;
    @(posedge clk);
    attention_event <= 1'h1;
    @(posedge clk);
    attention_event <= 1'h0;
  endtask : raise_event

  initial begin
    rst = 1'h1; reg_addr = 8'h00; reg_wdata = 16'h0000; reg_wr = 1'h0; reg_rd = 1'h0;
    attention_event = 1'h0; fatal_error = 1'h0; lat = 5'h2; err_addr = 16'hFFFF;
    // set characteristics, ack and interrupts on; host writes zeros in unused bits
    u_tpc_host_model.mem[0] = 16'h8084;
    u_tpc_host_model.mem[6] = 16'h808A;
    u_tpc_host_model.mem[7] = 16'h808F;
    u_tpc_host_model.mem[8] = 16'h800F;
    for (int i = 0; i < 8; i++) begin
      u_tpc_host_model.mem[32 + 4 * i] = 16'hF180 | {11'h000, codes[i]};
      u_tpc_host_model.mem[33 + 4 * i] = 16'h1230 + 16'(i);
    end
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rd(`TPC_OFS_STATUS_WORD, s); `CHK(s, 16'h0080)
    rd(8'h20, s); `CHK(s, 16'h0000)
    run(16'h0000, 4, 1, TPC_MSG_END, 1'h1, 16'h0088);
    `CHK(ex_r.code, 5'h04)
    rd(`TPC_OFS_IRQ_STATUS, s); `CHK(s[0], 1'h1)
    `CHK(irq, 1'h0)
    wr(`TPC_OFS_IRQ_MASK, 16'h0007);
    repeat (2) @(posedge clk); `CHK(irq, 1'h1)
    wr(`TPC_OFS_IRQ_STATUS, 16'h0007);
    repeat (2) @(posedge clk); `CHK(irq, 1'h0)
    for (int i = 0; i < 8; i++) begin
      run(16'(64 + 8 * i), (codes[i][4:3] == 2'h0) ? 4 : (codes[i] == 5'h08) ? 2 : 1,
          1, TPC_MSG_END, 1'h1, 16'h0088);
      `CHK(ex_r.code, codes[i])
      `CHK({ex_r.mode, ex_r.clear_volume_check, ex_r.reverse_execution}, 6'h07)
      `CHK({ex_r.byte_swap_select, ex_r.mode}, 5'h11)
      // a one-word packet leaves the parameter word of the last packet longer than one word
      `CHK(ex_r.param, 16'h1230 + 16'((i > 3) ? 3 : i))
    end
    lat <= 5'h14;
    wr(`TPC_OFS_CMD_PTR, 16'h000E);
    wr(`TPC_OFS_CMD_PTR, 16'h000E);
    m0 = n_msg; settle(1);
    lat <= 5'h2;
    rd(`TPC_OFS_STATUS_WORD, s); `CHK(s[0], 1'h1)
    rd(`TPC_OFS_IRQ_STATUS, s); `CHK(s[1], 1'h1)
    wr(`TPC_OFS_IRQ_STATUS, 16'h0007);
    run(16'h000C, 1, 0, TPC_MSG_END, 1'h0, 16'h008C);
    rd(`TPC_OFS_IRQ_STATUS, s); `CHK(s[0], 1'h1)
    wr(`TPC_OFS_CONTROL, 16'h0001);
    raise_event; settle(1);
    `CHK(n_msg - m0, 1)
    `CHK({mk_r, ma_r, s}, {TPC_MSG_NOTIFY, 1'h0, 16'h0088})
    raise_event; repeat (40) @(posedge clk); settle(0);
    `CHK(n_msg - m0, 0)
    `CHK(s, 16'h0088)
    run(16'h000E, 1, 1, TPC_MSG_END, 1'h1, 16'h0088);
    raise_event; settle(0);
    `CHK(s, 16'h008A)
    e0 = n_ex;
    run(16'h000E, 1, 1, TPC_MSG_NOTIFY, 1'h0, 16'h0088);
    `CHK(n_ex - e0, 0)
    run(16'h000E, 1, 1, TPC_MSG_END, 1'h1, 16'h0088);
    `CHK(n_ex - e0, 1)
    err_addr <= 16'h0030;
    run(16'h0030, 1, 1, TPC_MSG_FAIL, 1'h0, 16'hFFFF);
    err_addr <= 16'hFFFF;
    wr(`TPC_OFS_IRQ_STATUS, 16'h0007);
    run(16'h0010, 1, 1, TPC_MSG_END, 1'h1, 16'h0080);
    rd(`TPC_OFS_IRQ_STATUS, s); `CHK(s[0], 1'h0)
    // release again, then an ack command while the device still holds the buffer
    run(16'h000C, 1, 0, TPC_MSG_END, 1'h0, 16'h008C);
    run(16'h000E, 1, 1, TPC_MSG_END, 1'h1, 16'h0088);
    wr(`TPC_OFS_IRQ_STATUS, 16'h0007);
    @(posedge clk); fatal_error <= 1'h1;
    @(posedge clk); fatal_error <= 1'h0;
    rd(`TPC_OFS_IRQ_STATUS, s); `CHK(s[2], 1'h1)
    `CHK(irq, 1'h1)
    tally_and_finish;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish;
  end
endmodule : tb_top

// [tpc_core.sv]
// Local design decisions: the register offsets and the address-and-strobe port.
`include "tpc_map.svh"
module tpc_core (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [15:0]         reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [15:0]         reg_rdata,
  // packet fetch from host memory
  output logic                     mem_rd_req,
  output logic      [15:0]         mem_rd_addr,
  input  wire logic                mem_rd_valid,
  input  wire logic [15:0]         mem_rd_data,
  input  wire logic                mem_rd_err,
  // tape execution
  output logic                     exec_start,
  output tpc_pkg::tpc_exec_type    exec_cmd,
  input  wire logic                exec_done,
  input  wire logic                attention_event,
  input  wire logic                fatal_error,
  // message buffer writer
  output logic                     msg_wr_req,
  output tpc_pkg::tpc_msg_type     msg_kind,
  output logic                     msg_ack,
  input  wire logic                msg_wr_done,
  // interrupt
  output logic                     irq
);
  import tpc_pkg::*;

  tpc_st_type s;
  tpc_st_type n;

  // packet length in words from the command code
  function automatic logic [2:0] pkt_words(input logic [4:0] code);
    if (code[4:3] == 2'b00) begin
      pkt_words = 3'd4;
    end else if (code[4:3] == 2'b01) begin
      pkt_words = (code == TPC_CMD_POSITION) ? 3'd2 : 3'd1;
    end else begin
      pkt_words = 3'd1;
    end
  endfunction : pkt_words

  function automatic logic is_release(input logic [15:0] hdr);
    is_release = (hdr[`TPC_HDR_CODE_HI:`TPC_HDR_CODE_LO] == TPC_CMD_CONTROL) &&
                 (hdr[`TPC_HDR_MODE_HI:`TPC_HDR_MODE_LO] == 4'h0);
  endfunction : is_release

  logic        wr_ptr;
  logic [15:0] hdr_now;
  logic [2:0]  len_now;
  logic        last_word;
  logic        ev_done;
  logic        ev_ref;
  logic [2:0]  irq_set;
  logic [2:0]  irq_clr;

  assign wr_ptr = reg_wr && (reg_addr == `TPC_OFS_CMD_PTR);

  always_comb begin
    n            = s;
    n.mem_req    = 1'b0;
    n.exec_start = 1'b0;
    n.msg_req    = 1'b0;
    ev_done      = 1'b0;
    ev_ref       = 1'b0;
    hdr_now      = (s.widx == 2'd0) ? mem_rd_data : s.pkt[0];
    len_now      = (s.widx == 2'd0) ? pkt_words(mem_rd_data[4:0]) : s.wlen;
    last_word    = (({1'b0, s.widx} + 3'd1) == len_now);

    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `TPC_OFS_CMD_PTR: begin
          if (s.subsystem_ready_flag && s.state == TPC_ST_IDLE) begin
            n.command_pointer_register   = reg_wdata;
            n.subsystem_ready_flag       = 1'b0;
            n.modification_refused_error = 1'b0;
            n.widx                       = 2'd0;
            n.rd_pend                    = 1'b0;
            n.state                      = TPC_ST_FETCH;
          end else begin
            n.modification_refused_error = 1'b1;
            ev_ref                       = 1'b1;
          end
        end
        `TPC_OFS_IRQ_MASK: n.irq_msk     = reg_wdata[2:0];
        `TPC_OFS_CONTROL:  n.note_enable = reg_wdata[0];
        default: ;
      endcase
    end

    unique case (s.state)
      TPC_ST_IDLE: begin
        // attention only considered while nothing executes
        if (attention_event && s.note_enable && !s.note_blocked && !s.note_queued &&
            s.subsystem_ready_flag) begin
          if (s.msg_owned && !wr_ptr) begin
            n.subsystem_ready_flag = 1'b0;
            n.msg_req              = 1'b1;
            n.msg_kind             = TPC_MSG_NOTIFY;
            n.msg_ack              = 1'b0;
            n.state                = TPC_ST_NOTIFY;
          end else begin
            // no buffer held, or a racing pointer write wins; the attention waits for the next ack
            n.note_queued = 1'b1;
          end
        end
      end
      TPC_ST_FETCH: begin
        if (!s.rd_pend) begin
          n.mem_req  = 1'b1;
          n.mem_addr = s.command_pointer_register + {13'h0000, s.widx, 1'b0};
          n.rd_pend  = 1'b1;
        end else if (mem_rd_err) begin
          // the packet cannot be trusted, so no ownership change is taken from it
          n.rd_pend  = 1'b0;
          n.msg_req  = 1'b1;
          n.msg_kind = TPC_MSG_FAIL;
          n.msg_ack  = 1'b0;
          n.state    = TPC_ST_MSG;
        end else if (mem_rd_valid) begin
          n.rd_pend      = 1'b0;
          n.pkt[s.widx]  = mem_rd_data;
          n.wlen         = len_now;
          n.widx         = s.widx + 2'd1;
          if (last_word) begin
            if (hdr_now[`TPC_HDR_ACK]) begin
              n.msg_owned    = 1'b1;
              n.note_blocked = 1'b0;
            end
            if (s.note_queued && hdr_now[`TPC_HDR_ACK]) begin
              // command dropped; interrupt enable is left as it was
              n.msg_req  = 1'b1;
              n.msg_kind = TPC_MSG_NOTIFY;
              n.msg_ack  = 1'b0;
              n.state    = TPC_ST_NOTIFY;
            end else begin
              if (hdr_now[`TPC_HDR_FMT_HI:`TPC_HDR_FMT_LO] == `TPC_FMT_INT_ON) begin
                n.interrupt_enable_bit = 1'b1;
              end else if (hdr_now[`TPC_HDR_FMT_HI:`TPC_HDR_FMT_LO] == `TPC_FMT_INT_OFF) begin
                n.interrupt_enable_bit = 1'b0;
              end
              n.exec_start = 1'b1;
              n.state      = TPC_ST_EXEC;
            end
          end
        end
      end
      TPC_ST_EXEC: begin
        if (exec_done) begin
          if (is_release(s.pkt[0])) begin
            n.subsystem_ready_flag = 1'b1;
            ev_done                = 1'b1;
            n.state                = TPC_ST_IDLE;
          end else if (s.msg_owned) begin
            n.msg_req  = 1'b1;
            n.msg_kind = TPC_MSG_END;
            n.msg_ack  = 1'b1;
            n.state    = TPC_ST_MSG;
          end else begin
            // no buffer to write into: the ready flag and the done event are raised, no message
            n.subsystem_ready_flag = 1'b1;
            ev_done                = 1'b1;
            n.state                = TPC_ST_IDLE;
          end
        end
      end
      TPC_ST_MSG: begin
        if (msg_wr_done) begin
          n.subsystem_ready_flag = 1'b1;
          n.msg_owned            = 1'b0;
          ev_done                = 1'b1;
          n.state                = TPC_ST_IDLE;
        end
      end
      TPC_ST_NOTIFY: begin
        if (msg_wr_done) begin
          n.subsystem_ready_flag = 1'b1;
          n.msg_owned            = 1'b0;
          n.note_queued          = 1'b0;
          n.note_blocked         = 1'b1;
          ev_done                = 1'b1;
          n.state                = TPC_ST_IDLE;
        end
      end
    endcase

    // sticky interrupt status; a set in the clearing cycle wins
    irq_set                = 3'h0;
    irq_set[`TPC_IRQ_DONE]    = ev_done && n.interrupt_enable_bit;
    irq_set[`TPC_IRQ_REFUSED] = ev_ref;
    irq_set[`TPC_IRQ_FATAL]   = fatal_error;
    irq_clr = (reg_wr && reg_addr == `TPC_OFS_IRQ_STATUS) ? reg_wdata[2:0] : 3'h0;
    n.irq_sts = (s.irq_sts & ~irq_clr) | irq_set;
    n.irq     = |(n.irq_sts & n.irq_msk);

    // read data for the cycle after the strobe
    n.rdata = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `TPC_OFS_CMD_PTR: n.rdata = s.command_pointer_register;
        `TPC_OFS_STATUS_WORD: begin
          n.rdata[`TPC_SW_REFUSED]     = s.modification_refused_error;
          n.rdata[`TPC_SW_NOTE_QUEUED] = s.note_queued;
          n.rdata[`TPC_SW_MSG_OWNED]   = s.msg_owned;
          n.rdata[`TPC_SW_INT_EN]      = s.interrupt_enable_bit;
          n.rdata[`TPC_SW_READY]       = s.subsystem_ready_flag;
        end
        `TPC_OFS_IRQ_STATUS:  n.rdata = {13'h0000, s.irq_sts};
        `TPC_OFS_IRQ_MASK:    n.rdata = {13'h0000, s.irq_msk};
        `TPC_OFS_CONTROL:     n.rdata = {15'h0000, s.note_enable};
        `TPC_OFS_LAST_HEADER: n.rdata = s.pkt[0];
        default:              n.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s                      <= '0;
      s.state                <= TPC_ST_IDLE;
      s.subsystem_ready_flag <= 1'b1;
      s.irq_msk              <= `TPC_RST_IRQ_MASK;
      s.note_enable          <= `TPC_RST_CONTROL;
      s.msg_kind             <= TPC_MSG_END;
    end else begin
      s <= n;
    end
  end

  // outputs come straight from the state register
  assign reg_rdata   = s.rdata;
  assign mem_rd_req  = s.mem_req;
  assign mem_rd_addr = s.mem_addr;
  assign exec_start  = s.exec_start;
  assign msg_wr_req  = s.msg_req;
  assign msg_kind    = s.msg_kind;
  assign msg_ack     = s.msg_ack;
  assign irq         = s.irq;

  // packet word decode; only meaningful once exec_start has pulsed
  assign exec_cmd.code               = s.pkt[0][`TPC_HDR_CODE_HI:`TPC_HDR_CODE_LO];
  assign exec_cmd.mode               = s.pkt[0][`TPC_HDR_MODE_HI:`TPC_HDR_MODE_LO];
  assign exec_cmd.clear_volume_check = s.pkt[0][`TPC_HDR_CLR_VOL];
  assign exec_cmd.reverse_execution  = s.pkt[0][`TPC_HDR_REV];
  assign exec_cmd.byte_swap_select   = s.pkt[0][`TPC_HDR_SWAP];
  assign exec_cmd.buf_addr           = {s.pkt[2], s.pkt[1]};
  assign exec_cmd.count              = s.pkt[3];
  assign exec_cmd.param              = s.pkt[1];

  a_ptr_clears_ready: assert property (@(posedge clk) disable iff (rst)
    (wr_ptr && s.subsystem_ready_flag && s.state == TPC_ST_IDLE)
      |=> (!s.subsystem_ready_flag && s.state == TPC_ST_FETCH))
    else $error("pointer write did not clear ready");

  a_busy_write_refused: assert property (@(posedge clk) disable iff (rst)
    (wr_ptr && !s.subsystem_ready_flag)
      |=> (s.modification_refused_error && $stable(s.command_pointer_register)))
    else $error("busy pointer write not refused");

  a_note_not_exec: assert property (@(posedge clk) disable iff (rst)
    $rose(s.state == TPC_ST_NOTIFY) |-> ($past(s.state) != TPC_ST_EXEC))
    else $error("attention started during execution");

  a_queue_holds: assert property (@(posedge clk) disable iff (rst)
    (s.note_queued && s.state != TPC_ST_NOTIFY) |=> s.note_queued)
    else $error("queued attention lost");

  a_note_drops_cmd: assert property (@(posedge clk) disable iff (rst)
    (s.msg_req && s.msg_kind == TPC_MSG_NOTIFY)
      |-> (!s.msg_ack && !s.exec_start))
    else $error("attention message with ack or command run");

  a_release_no_msg: assert property (@(posedge clk) disable iff (rst)
    (s.state == TPC_ST_EXEC && exec_done && is_release(s.pkt[0]))
      |=> (!s.msg_req && s.subsystem_ready_flag && $stable(s.msg_owned)))
    else $error("release command misbehaved");

  a_note_held_buf: assert property (@(posedge clk) disable iff (rst)
    ($rose(s.state == TPC_ST_NOTIFY) && $past(s.state) == TPC_ST_IDLE)
      |-> (s.msg_req && !s.msg_ack && !s.subsystem_ready_flag && $past(s.msg_owned)))
    else $error("attention from idle without held buffer");

  a_note_blocked: assert property (@(posedge clk) disable iff (rst)
    (s.state == TPC_ST_IDLE && s.note_blocked) |=> (s.state != TPC_ST_NOTIFY))
    else $error("attention while blocked");

  a_ack_takes_buf: assert property (@(posedge clk) disable iff (rst)
    (s.state == TPC_ST_FETCH && s.rd_pend && !mem_rd_err && mem_rd_valid && last_word &&
     hdr_now[`TPC_HDR_ACK]) |=> s.msg_owned)
    else $error("ack header did not hand over the buffer");

  a_code_sets_len: assert property (@(posedge clk) disable iff (rst)
    (s.state == TPC_ST_FETCH && s.rd_pend && !mem_rd_err && mem_rd_valid &&
     s.widx == 2'd0 && mem_rd_data[4:3] == 2'b00) |=> (s.wlen == 3'd4))
    else $error("four-word packet length not taken");

  a_fatal_sets: assert property (@(posedge clk) disable iff (rst)
    fatal_error |=> s.irq_sts[`TPC_IRQ_FATAL])
    else $error("fatal error not recorded");

  a_fetch_err_fail: assert property (@(posedge clk) disable iff (rst)
    (s.state == TPC_ST_FETCH && s.rd_pend && mem_rd_err)
      |=> (s.msg_req && s.msg_kind == TPC_MSG_FAIL && s.state == TPC_ST_MSG))
    else $error("bus error gave no failure message");

  a_int_from_format: assert property (@(posedge clk) disable iff (rst)
    (s.exec_start && s.pkt[0][`TPC_HDR_FMT_HI:`TPC_HDR_FMT_LO] == `TPC_FMT_INT_ON)
      |-> s.interrupt_enable_bit)
    else $error("format 100 did not enable interrupts");

  a_format_off: assert property (@(posedge clk) disable iff (rst)
    (s.exec_start && s.pkt[0][`TPC_HDR_FMT_HI:`TPC_HDR_FMT_LO] == `TPC_FMT_INT_OFF)
      |-> !s.interrupt_enable_bit)
    else $error("format 000 did not disable interrupts");

  a_done_waits_en: assert property (@(posedge clk) disable iff (rst)
    ($rose(s.subsystem_ready_flag) && !s.interrupt_enable_bit && !$past(s.irq_sts[0]))
      |-> !s.irq_sts[0])
    else $error("done interrupt without enable");

endmodule : tpc_core

// [tpc_host_model.sv]
module tpc_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // behaviour knobs
  input  wire logic [4:0]  lat,
  input  wire logic [15:0] err_addr,
  // packet fetch from host memory
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_rd_addr,
  output logic             mem_rd_valid,
  output logic [15:0]      mem_rd_data,
  output logic             mem_rd_err,
  // tape execution and message writer
  input  wire logic        exec_start,
  output logic             exec_done,
  input  wire logic        msg_wr_req,
  output logic             msg_wr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:63];
  logic [15:0] addr_r;
  logic [4:0]  rd_cnt_r;
  logic [4:0]  ex_cnt_r;
  logic [4:0]  msg_cnt_r;
  logic        rd_busy_r;
  logic        ex_busy_r;
  logic        msg_busy_r;

  // data line toggles outside answers so a stale word is never mistaken for a good one
  always @(posedge clk) begin
    mem_rd_valid <= 1'h0;
    mem_rd_err   <= 1'h0;
    mem_rd_data  <= ~mem_rd_data;
    if (rst) begin
      rd_busy_r   <= 1'h0;
      mem_rd_data <= 16'h0000;
    end else if (mem_rd_req) begin
      rd_busy_r <= 1'h1;
      rd_cnt_r  <= lat;
      addr_r    <= mem_rd_addr;
    end else if (rd_busy_r && rd_cnt_r == 5'h0) begin
      rd_busy_r <= 1'h0;
      if (addr_r == err_addr) begin
        mem_rd_err <= 1'h1;
      end else begin
        mem_rd_valid <= 1'h1;
        mem_rd_data  <= mem[addr_r[6:1]];
      end
    end else begin
      rd_cnt_r <= rd_cnt_r - 5'h1;
    end
  end

  always @(posedge clk) begin
    exec_done   <= 1'h0;
    msg_wr_done <= 1'h0;
    if (rst) begin
      ex_busy_r  <= 1'h0;
      msg_busy_r <= 1'h0;
    end else begin
      if (exec_start) begin
        ex_busy_r <= 1'h1;
        ex_cnt_r  <= lat;
      end else if (ex_busy_r && ex_cnt_r == 5'h0) begin
        ex_busy_r <= 1'h0;
        exec_done <= 1'h1;
      end else begin
        ex_cnt_r <= ex_cnt_r - 5'h1;
      end
      if (msg_wr_req) begin
        msg_busy_r <= 1'h1;
        msg_cnt_r  <= lat;
      end else if (msg_busy_r && msg_cnt_r == 5'h0) begin
        msg_busy_r  <= 1'h0;
        msg_wr_done <= 1'h1;
      end else begin
        msg_cnt_r <= msg_cnt_r - 5'h1;
      end
    end
  end
endmodule : tpc_host_model

// [tpc_map.svh]
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH

// register byte offsets on the plain register port
`define TPC_OFS_CMD_PTR      8'h00
`define TPC_OFS_STATUS_WORD  8'h04
`define TPC_OFS_IRQ_STATUS   8'h08
`define TPC_OFS_IRQ_MASK     8'h0C
`define TPC_OFS_CONTROL      8'h10
`define TPC_OFS_LAST_HEADER  8'h14

// header word field positions
`define TPC_HDR_ACK          15
`define TPC_HDR_CLR_VOL      14
`define TPC_HDR_REV          13
`define TPC_HDR_SWAP         12
`define TPC_HDR_MODE_HI      11
`define TPC_HDR_MODE_LO      8
`define TPC_HDR_FMT_HI       7
`define TPC_HDR_FMT_LO       5
`define TPC_HDR_CODE_HI      4
`define TPC_HDR_CODE_LO      0

// packet format values
`define TPC_FMT_INT_OFF      3'h0
`define TPC_FMT_INT_ON       3'h4

// status word bit positions
`define TPC_SW_REFUSED       0
`define TPC_SW_NOTE_QUEUED   1
`define TPC_SW_MSG_OWNED     2
`define TPC_SW_INT_EN        3
`define TPC_SW_READY         7

// interrupt status bits
`define TPC_IRQ_DONE         0
`define TPC_IRQ_REFUSED      1
`define TPC_IRQ_FATAL        2

// reset values
`define TPC_RST_IRQ_MASK     3'h0
`define TPC_RST_CONTROL      1'b0

`endif

// [tpc_pkg.sv]
package tpc_pkg;

  typedef enum logic [2:0] {
    TPC_ST_IDLE  = 3'h0,
    TPC_ST_FETCH = 3'h1,
    TPC_ST_EXEC  = 3'h3,
    TPC_ST_MSG   = 3'h2,
    TPC_ST_NOTIFY = 3'h6
  } tpc_state_type;

  typedef enum logic [1:0] {
    TPC_MSG_END  = 2'h0,
    TPC_MSG_NOTIFY = 2'h1,
    TPC_MSG_FAIL = 2'h2
  } tpc_msg_type;

  typedef enum logic [4:0] {
    TPC_CMD_READ     = 5'h01,
    TPC_CMD_SETCHAR  = 5'h04,
    TPC_CMD_WRITE    = 5'h05,
    TPC_CMD_POSITION = 5'h08,
    TPC_CMD_FORMAT   = 5'h09,
    TPC_CMD_CONTROL  = 5'h0A,
    TPC_CMD_INIT     = 5'h0B,
    TPC_CMD_STATUS   = 5'h0F
  } tpc_cmd_type;

  // decoded command handed to the tape execution logic
  typedef struct packed {
    logic [4:0]  code;
    logic [3:0]  mode;
    logic        clear_volume_check;
    logic        reverse_execution;
    logic        byte_swap_select;
    logic [31:0] buf_addr;
    logic [15:0] count;
    logic [15:0] param;
  } tpc_exec_type;

  typedef struct packed {
    tpc_state_type   state;
    logic            subsystem_ready_flag;
    logic            modification_refused_error;
    logic            msg_owned;
    logic            note_queued;
    logic            note_blocked;
    logic            interrupt_enable_bit;
    logic            note_enable;
    logic [15:0]     command_pointer_register;
    logic [1:0]      widx;
    logic [2:0]      wlen;
    logic            rd_pend;
    logic [3:0][15:0] pkt;
    logic [2:0]      irq_sts;
    logic [2:0]      irq_msk;
    logic [15:0]     rdata;
    logic            mem_req;
    logic [15:0]     mem_addr;
    logic            exec_start;
    logic            msg_req;
    tpc_msg_type     msg_kind;
    logic            msg_ack;
    logic            irq;
  } tpc_st_type;

endpackage : tpc_pkg
